// ===== sim/ct_model.sv
// Current transformer stand-in: load current when heating, leakage when not
`default_nettype none

module ct_model (
   input wire logic heatingOn,
   input wire logic [15:0] loadCurrent,
   input wire logic [15:0] leakCurrent,
   output logic [15:0] currentSense
);
   timeunit 1ns;
   timeprecision 1ps;
   // Heater supply live from time zero, never after the controller
   assign currentSense = heatingOn ? loadCurrent : leakCurrent;
endmodule : ct_model

`default_nettype wire

// ===== sim/heater_alarm_properties.sv
// Concurrent checks on the ports of the heater current and rate alarm block
`default_nettype none

module heater_alarm_properties
   import heater_alarm_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic sampleTick,
   input wire logic heatingOn,
   input wire logic [3:0] alarm1Type,
   input wire logic alarmLatchEnable,
   input wire logic signed [15:0] remoteSetPoint,
   input wire logic signed [15:0] alarm1Value,
   input wire logic [15:0] openThresholdA,
   input wire logic [15:0] openThresholdB,
   input wire logic [15:0] leakThresholdB,
   input wire logic [15:0] overThresholdB,
   input wire logic firstAlarmOutput,
   input wire logic pvRateAlarm,
   input wire logic rspUpperAlarm,
   input wire logic rspLowerAlarm,
   input wire logic heaterOpenAlarmA,
   input wire logic heaterOpenAlarmB,
   input wire logic heaterLeakShortAlarmA,
   input wire logic heaterLeakShortAlarmB,
   input wire logic heaterOvercurrentAlarmA,
   input wire logic heaterOvercurrentAlarmB,
   input wire logic [15:0] heaterCurrentMonitorA
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   logic anyHeater;
   assign anyHeater = heaterOpenAlarmA | heaterOpenAlarmB | heaterLeakShortAlarmA
      | heaterLeakShortAlarmB | heaterOvercurrentAlarmA | heaterOvercurrentAlarmB;

   a_open_forced: assert property (openThresholdA >= CUR_FORCE_HIGH |=> heaterOpenAlarmA)
      else $error("open alarm not forced on");
   a_over_forced: assert property (overThresholdB == CUR_FORCE_LOW |=> heaterOvercurrentAlarmB)
      else $error("overcurrent alarm not forced on");
   a_leak_forced: assert property (leakThresholdB >= CUR_FORCE_HIGH |=> !heaterLeakShortAlarmB)
      else $error("leak alarm not forced off");
   a_open_zero_off: assert property (openThresholdB == CUR_FORCE_LOW |=> !heaterOpenAlarmB)
      else $error("open alarm not forced off");
   a_monitor_range: assert property (heaterCurrentMonitorA != CUR_OVERFLOW_CODE
      |-> heaterCurrentMonitorA <= CUR_OVERFLOW_LIMIT)
      else $error("monitor shows value above limit");
   // Hold between intervals; first edge after reset still sees reset values
   a_open_holds: assert property ($past(rst_b) && $stable(heatingOn)
      && $stable(openThresholdA) |=> $stable(heaterOpenAlarmA))
      else $error("open alarm moved without interval end");
   a_heater_first: assert property (heaterOpenAlarmA |-> ##2 firstAlarmOutput)
      else $error("heater alarm missing from first alarm");
   a_type_off_quiet: assert property ((alarm1Type == ALM_TYPE_OFF && !alarmLatchEnable
      && !anyHeater) [*3] |=> !firstAlarmOutput)
      else $error("first alarm set with nothing active");
   a_rate_on_tick: assert property (!sampleTick |=> $stable(pvRateAlarm))
      else $error("rate alarm moved without tick");
   a_rsp_upper: assert property (remoteSetPoint > alarm1Value |=> rspUpperAlarm)
      else $error("remote upper alarm missing");
   a_rsp_lower: assert property (remoteSetPoint < alarm1Value |=> rspLowerAlarm)
      else $error("remote lower alarm missing");

   c_open: cover property ($rose(heaterOpenAlarmA) && openThresholdA < CUR_FORCE_HIGH);
   c_rate: cover property ($rose(pvRateAlarm));
   c_first: cover property ($fell(firstAlarmOutput));
endmodule : heater_alarm_properties

bind heater_current_and_rate_alarms heater_alarm_properties u_props (.*);

`default_nettype wire

// ===== sim/testbench.sv
// Directed bench for the heater current and rate alarm block
`default_nettype none
`define CHECK(got, exp) begin checks_done++; if ((got) !== (exp)) begin n_fail++; \
   $display("wrong value at %0t: got %h exp %h", $time, got, exp); end end

module testbench;
   import heater_alarm_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk_sys = 1'h0, rst_b = 1'h0, sampleTick = 1'h0, heatingOn = 1'h0;
   logic signed [15:0] processValue = 16'sh0000, rateAlarmValue = 16'sh000A;
   logic signed [15:0] alarm1Value = 16'sh0064, remoteSetPoint = 16'sh0064;
   logic [9:0] rateCalcPeriod = 10'h002;
   logic [3:0] alarm1Type = 4'h0;
   logic [15:0] alarm1Hysteresis = 16'h0000;
   logic alarm1OtherFunction = 1'h0, alarmLatchEnable = 1'h0, alarmLatchClear = 1'h0;
   // Open thresholds midway: 2.5 A between 5.0 A and 0 A; leak threshold 2.5 A sits 0.5 A under 3.0 A
   logic [15:0] openThresholdA = 16'h0019, openThresholdB = 16'h0019;
   logic [15:0] leakThresholdA = 16'h0019, leakThresholdB = 16'h0019;
   logic [15:0] overThresholdA = 16'h00C8, overThresholdB = 16'h00C8;
   logic [15:0] loadA = 16'h0000, loadB = 16'h0032, leakA = 16'h0000, leakB = 16'h001E;
   logic [15:0] currentSenseChanA, currentSenseChanB;
   logic firstAlarmOutput, pvRateAlarm, rspUpperAlarm, rspLowerAlarm;
   logic heaterOpenAlarmA, heaterOpenAlarmB, heaterLeakShortAlarmA, heaterLeakShortAlarmB;
   logic heaterOvercurrentAlarmA, heaterOvercurrentAlarmB;
   logic [15:0] heaterCurrentMonitorA, heaterCurrentMonitorB;
   logic [15:0] leakageCurrentMonitorA, leakageCurrentMonitorB;
   int n_fail = 0, checks_done = 0;

   // Short minimum interval keeps each heater phase to tens of cycles
   heater_current_and_rate_alarms #(.MIN_CYCLES(20)) dut (.*);
   ct_model ctA (.heatingOn(heatingOn), .loadCurrent(loadA), .leakCurrent(leakA),
      .currentSense(currentSenseChanA));
   ct_model ctB (.heatingOn(heatingOn), .loadCurrent(loadB), .leakCurrent(leakB),
      .currentSense(currentSenseChanB));

   always #4 clk_sys = ~clk_sys;

   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask : cyc

   task automatic tick2(input logic signed [15:0] a, input logic signed [15:0] b);
      for (int i = 0; i < 2; i++) begin
         processValue = (i == 0) ? a : b;
         sampleTick = 1'h1;
         cyc(1);
         sampleTick = 1'h0;
         cyc(1);
      end
   endtask : tick2

   // No tick in the switching cycle, which the block drops
   task automatic phase(input logic on, input int n);
      heatingOn = on;
      for (int i = 0; i < n; i++) begin
         sampleTick = (i % 4 == 2);
         cyc(1);
      end
      sampleTick = 1'h0;
   endtask : phase

   task automatic test_rate;
      alarm1Type = ALM_TYPE_PV_RATE;
      tick2(16'sh0000, 16'sh0000);
      tick2(16'sh0005, 16'sh0019);
      `CHECK(pvRateAlarm, 1'h1)
      cyc(2);
      `CHECK(firstAlarmOutput, 1'h1)
      tick2(16'sh001E, 16'sh0014);
      `CHECK(pvRateAlarm, 1'h0)
      rateAlarmValue = -16'sh000A;
      tick2(16'sh000F, 16'sh0005);
      `CHECK(pvRateAlarm, 1'h1)
      alarmLatchEnable = 1'h1;
      cyc(3);
      tick2(16'sh0005, 16'sh0005);
      `CHECK({pvRateAlarm, firstAlarmOutput}, 2'h1)
      alarmLatchClear = 1'h1;
      cyc(3);
      `CHECK(firstAlarmOutput, 1'h0)
      alarmLatchClear = 1'h0;
      alarmLatchEnable = 1'h0;
      cyc(3);
      `CHECK(firstAlarmOutput, 1'h0)
      rateCalcPeriod = 10'h001;
      rateAlarmValue = 16'sh000A;
      tick2(16'sh0005, 16'sh0014);
      `CHECK(pvRateAlarm, 1'h1)
      tick2(16'sh0014, 16'sh0014);
      `CHECK(pvRateAlarm, 1'h0)
      // Zero period falls back to 17 ticks
      rateCalcPeriod = 10'h000;
      repeat (8) tick2(16'sh0064, 16'sh0064);
      `CHECK(pvRateAlarm, 1'h0)
      tick2(16'sh0064, 16'sh0064);
      `CHECK(pvRateAlarm, 1'h1)
      $display("test rate done");
   endtask : test_rate

   task automatic test_rsp;
      alarm1Type = ALM_TYPE_RSP_UPPER;
      remoteSetPoint = 16'sh0096;
      cyc(3);
      `CHECK({rspUpperAlarm, rspLowerAlarm, firstAlarmOutput}, 3'h5)
      alarm1Hysteresis = 16'h0014;
      remoteSetPoint = 16'sh005A;
      cyc(3);
      `CHECK(rspUpperAlarm, 1'h1)
      alarm1Type = ALM_TYPE_RSP_LOWER;
      remoteSetPoint = 16'sh0032;
      cyc(3);
      `CHECK({rspUpperAlarm, rspLowerAlarm, firstAlarmOutput}, 3'h3)
      alarm1Hysteresis = 16'h0000;
      alarm1Type = 4'h2;
      alarm1OtherFunction = 1'h1;
      remoteSetPoint = 16'sh0064;
      cyc(3);
      `CHECK({rspUpperAlarm, rspLowerAlarm, firstAlarmOutput}, 3'h1)
      alarm1Type = ALM_TYPE_OFF;
      cyc(3);
      `CHECK(firstAlarmOutput, 1'h0)
      $display("test rsp done");
   endtask : test_rsp

   task automatic test_heater;
      phase(1'h1, 40);
      phase(1'h0, 3);
      `CHECK({heaterOpenAlarmA, heaterOpenAlarmB}, 2'h2)
      `CHECK({heaterOvercurrentAlarmA, heaterOvercurrentAlarmB}, 2'h0)
      `CHECK({heaterCurrentMonitorA, heaterCurrentMonitorB}, 32'h00000032)
      `CHECK(firstAlarmOutput, 1'h1)
      phase(1'h0, 40);
      phase(1'h1, 3);
      `CHECK({heaterLeakShortAlarmA, heaterLeakShortAlarmB}, 2'h1)
      `CHECK({leakageCurrentMonitorA, leakageCurrentMonitorB}, 32'h0000001E)
      loadA = 16'h0032;
      leakB = 16'h0000;
      phase(1'h1, 10);
      phase(1'h0, 10);
      phase(1'h1, 40);
      `CHECK(heaterOpenAlarmA, 1'h1)
      `CHECK(heaterLeakShortAlarmB, 1'h1)
      phase(1'h0, 3);
      `CHECK(heaterOpenAlarmA, 1'h0)
      loadA = 16'h0258;
      phase(1'h1, 40);
      phase(1'h0, 3);
      `CHECK({heaterOvercurrentAlarmA, heaterOpenAlarmA}, 2'h2)
      `CHECK(heaterCurrentMonitorA, 16'hFFFF)
      $display("test heater done");
   endtask : test_heater

   task automatic test_force;
      openThresholdA = 16'h01F4;
      overThresholdA = 16'h01F4;
      leakThresholdA = 16'h0000;
      openThresholdB = 16'h0000;
      overThresholdB = 16'h0000;
      leakThresholdB = 16'h01F4;
      cyc(2);
      `CHECK({heaterOpenAlarmA, heaterOvercurrentAlarmA, heaterLeakShortAlarmA}, 3'h5)
      `CHECK({heaterOpenAlarmB, heaterOvercurrentAlarmB, heaterLeakShortAlarmB}, 3'h2)
      $display("test force done");
   endtask : test_force

   task automatic summarize;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : summarize

   initial begin
      cyc(6);
      rst_b = 1'h1;
      test_rate;
      test_rsp;
      test_heater;
      test_force;
      summarize;
   end

   initial begin
      repeat (20000) @(negedge clk_sys);
      n_fail++;
      summarize;
   end
endmodule : testbench

`undef CHECK
`default_nettype wire

// ===== src/heater_alarm_pkg.sv
// Constants and types shared by the heater current and rate alarm logic
`default_nettype none

package heater_alarm_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 8;
   localparam int SAMPLE_PERIOD_MS = 60;
   localparam int MIN_INTERVAL_MS = 100;
   // Intervals at or below this count are too short to be judged
   localparam int MIN_INTERVAL_CYCLES = MIN_INTERVAL_MS * 1000000 / CLK_PERIOD_NS;
   localparam int INTERVAL_CNT_W = 24;

   // ----------------------------------------------------------------
   // Rate calculation period, in sampling cycles
   // ----------------------------------------------------------------
   localparam logic [9:0] RATE_PERIOD_MIN = 10'h001;
   localparam logic [9:0] RATE_PERIOD_MAX = 10'h3E7;
   localparam logic [9:0] RATE_PERIOD_DEFAULT = 10'h011;
   localparam logic [9:0] RATE_TICK_RESET = 10'h000;

   // ----------------------------------------------------------------
   // Currents, in units of 0.1 A
   // ----------------------------------------------------------------
   localparam int CURRENT_W = 16;
   localparam int CHANNELS = 2;
   localparam logic [15:0] CUR_FORCE_LOW = 16'h0000;
   localparam logic [15:0] CUR_FORCE_HIGH = 16'h01F4;
   localparam logic [15:0] CUR_OVERFLOW_LIMIT = 16'h0226;
   localparam logic [15:0] CUR_OVERFLOW_CODE = 16'hFFFF;
   localparam logic [15:0] CUR_MONITOR_RESET = 16'h0000;

   // ----------------------------------------------------------------
   // Alarm-1 type codes
   // ----------------------------------------------------------------
   localparam logic [3:0] ALM_TYPE_OFF = 4'h0;
   localparam logic [3:0] ALM_TYPE_PV_RATE = 4'hD;
   localparam logic [3:0] ALM_TYPE_RSP_UPPER = 4'hE;
   localparam logic [3:0] ALM_TYPE_RSP_LOWER = 4'hF;

   // ----------------------------------------------------------------
   // Rate alarm sequencing
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      RATE_PRIME = 2'b01,
      RATE_RUN = 2'b10
   } rate_state_e;

endpackage : heater_alarm_pkg

`default_nettype wire

// ===== src/heater_current_and_rate_alarms.sv
// Process-value rate alarm, remote set-point alarms and heater current alarms
//
// Behaviour
// - Each period end, present minus previous value compared with alarm value.
// - Period is 1 to 999 sampling cycles of 60 ms, default 17.
// - Positive alarm value watches rises, negative value watches falls.
// - Remote set-point limit alarms always use remote set point, any mode.
// - Open and overcurrent use on-time current; leak-short uses off-time current.
// - Heater alarms follow only the heating output, never cooling.
// - Open alarm on below threshold, off above, during on interval.
// - Leak-short alarm on above threshold, off below, during off interval.
// - Overcurrent alarm on above threshold, off below, during on interval.
// - On intervals of 100 ms or less skip open and overcurrent checks.
// - Off intervals of 100 ms or less skip leak-short check.
// - First alarm output ORs alarm-1 function with the heater alarms.
// - Heater alarms never change the control output.
// - Thresholds detect within 0.1 to 49.9 A; 0.0 and 50.0 disable.
// - Threshold 0.0 forces open off, leak-short and overcurrent on.
// - Threshold 50.0 forces open on, leak-short and overcurrent off.
// - Monitors show FFFF once current exceeds 55.0 A.
// - Two independent current channels, each with own thresholds and monitors.
// - Alarm type 13 selects the rate alarm.
// - Alarm types 14 and 15 select remote set-point upper and lower.
`default_nettype none

module heater_current_and_rate_alarms
   import heater_alarm_pkg::*;
#(
   parameter int MIN_CYCLES = MIN_INTERVAL_CYCLES
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic sampleTick,
   input wire logic signed [15:0] processValue,
   input wire logic [9:0] rateCalcPeriod,
   input wire logic signed [15:0] rateAlarmValue,
   input wire logic [3:0] alarm1Type,
   input wire logic signed [15:0] alarm1Value,
   input wire logic [15:0] alarm1Hysteresis,
   input wire logic alarm1OtherFunction,
   input wire logic alarmLatchEnable,
   input wire logic alarmLatchClear,
   input wire logic signed [15:0] remoteSetPoint,
   input wire logic heatingOn,
   input wire logic [15:0] currentSenseChanA,
   input wire logic [15:0] currentSenseChanB,
   input wire logic [15:0] openThresholdA,
   input wire logic [15:0] openThresholdB,
   input wire logic [15:0] leakThresholdA,
   input wire logic [15:0] leakThresholdB,
   input wire logic [15:0] overThresholdA,
   input wire logic [15:0] overThresholdB,
   output logic firstAlarmOutput,
   output logic pvRateAlarm,
   output logic rspUpperAlarm,
   output logic rspLowerAlarm,
   output logic heaterOpenAlarmA,
   output logic heaterOpenAlarmB,
   output logic heaterLeakShortAlarmA,
   output logic heaterLeakShortAlarmB,
   output logic heaterOvercurrentAlarmA,
   output logic heaterOvercurrentAlarmB,
   output logic [15:0] heaterCurrentMonitorA,
   output logic [15:0] heaterCurrentMonitorB,
   output logic [15:0] leakageCurrentMonitorA,
   output logic [15:0] leakageCurrentMonitorB
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      rate_state_e rateState;
      logic [9:0] tickCnt;
      logic signed [15:0] prevPv;
      logic rateAlarm;
      logic rspUpper;
      logic rspLower;
      logic heaterAny;
      logic alarm1Latched;
      logic firstAlarm;
   } top_state_s;

   top_state_s s_q;
   top_state_s s_d;

   // ----------------------------------------------------------------
   // Current channels
   // ----------------------------------------------------------------
   logic [15:0] senseArr [CHANNELS];
   logic [15:0] openThrArr [CHANNELS];
   logic [15:0] leakThrArr [CHANNELS];
   logic [15:0] overThrArr [CHANNELS];
   logic [CHANNELS-1:0] openArr;
   logic [CHANNELS-1:0] leakArr;
   logic [CHANNELS-1:0] overArr;
   logic [15:0] onMonArr [CHANNELS];
   logic [15:0] offMonArr [CHANNELS];

   assign senseArr[0] = currentSenseChanA;
   assign senseArr[1] = currentSenseChanB;
   assign openThrArr[0] = openThresholdA;
   assign openThrArr[1] = openThresholdB;
   assign leakThrArr[0] = leakThresholdA;
   assign leakThrArr[1] = leakThresholdB;
   assign overThrArr[0] = overThresholdA;
   assign overThrArr[1] = overThresholdB;

   // heatingOn is only observed here; the control output stays untouched
   for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
      heater_current_channel #(
         .MIN_CYCLES(MIN_CYCLES)
      ) u_chan (
         .clk_sys(clk_sys),
         .rst_b(rst_b),
         .sampleTick(sampleTick),
         .heatingOn(heatingOn),
         .currentSense(senseArr[ch]),
         .openThreshold(openThrArr[ch]),
         .leakThreshold(leakThrArr[ch]),
         .overThreshold(overThrArr[ch]),
         .heaterOpenAlarm(openArr[ch]),
         .heaterLeakShortAlarm(leakArr[ch]),
         .heaterOvercurrentAlarm(overArr[ch]),
         .heaterCurrentMonitor(onMonArr[ch]),
         .leakageCurrentMonitor(offMonArr[ch])
      );
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   logic [9:0] periodEff;
   logic [9:0] tickNext;
   logic [16:0] pvDiff;
   logic [16:0] rateValExt;
   logic [17:0] rspExt;
   logic [17:0] limExt;
   logic [17:0] hystExt;
   logic alarm1Func;
   logic combined;

   always_comb begin
      s_d = s_q;
      // Out-of-range period: zero falls back to default, large is clamped
      if (rateCalcPeriod < RATE_PERIOD_MIN) begin
         periodEff = RATE_PERIOD_DEFAULT;
      end else if (rateCalcPeriod > RATE_PERIOD_MAX) begin
         periodEff = RATE_PERIOD_MAX;
      end else begin
         periodEff = rateCalcPeriod;
      end
      tickNext = s_q.tickCnt + 10'h001;
      pvDiff = {processValue[15], processValue} - {s_q.prevPv[15], s_q.prevPv};
      rateValExt = {rateAlarmValue[15], rateAlarmValue};

      // Rate alarm: first period only primes the previous value
      if (sampleTick) begin
         if (tickNext >= periodEff) begin
            s_d.tickCnt = RATE_TICK_RESET;
            s_d.prevPv = processValue;
            case (s_q.rateState)
               RATE_PRIME: begin
                  s_d.rateState = RATE_RUN;
               end
               RATE_RUN: begin
                  if (!rateAlarmValue[15]) begin
                     s_d.rateAlarm = $signed(pvDiff) > $signed(rateValExt);
                  end else begin
                     s_d.rateAlarm = $signed(pvDiff) < $signed(rateValExt);
                  end
               end
               default: begin
                  s_d.rateState = RATE_PRIME;
                  s_d.rateAlarm = 1'b0;
               end
            endcase
         end else begin
            s_d.tickCnt = tickNext;
         end
      end

      // Remote set-point absolute limits, with hysteresis on release
      rspExt = {{2{remoteSetPoint[15]}}, remoteSetPoint};
      limExt = {{2{alarm1Value[15]}}, alarm1Value};
      hystExt = {2'b00, alarm1Hysteresis};
      if ($signed(rspExt) > $signed(limExt)) begin
         s_d.rspUpper = 1'b1;
      end else if ($signed(rspExt) <= $signed(limExt - hystExt)) begin
         s_d.rspUpper = 1'b0;
      end
      if ($signed(rspExt) < $signed(limExt)) begin
         s_d.rspLower = 1'b1;
      end else if ($signed(rspExt) >= $signed(limExt + hystExt)) begin
         s_d.rspLower = 1'b0;
      end

      s_d.heaterAny = (|openArr) | (|leakArr) | (|overArr);

      case (alarm1Type)
         ALM_TYPE_OFF: alarm1Func = 1'b0;
         ALM_TYPE_PV_RATE: alarm1Func = s_q.rateAlarm;
         ALM_TYPE_RSP_UPPER: alarm1Func = s_q.rspUpper;
         ALM_TYPE_RSP_LOWER: alarm1Func = s_q.rspLower;
         default: alarm1Func = alarm1OtherFunction;
      endcase
      combined = alarm1Func | s_q.heaterAny;

      // Latch: a fresh alarm beats a clear in the same cycle
      if (combined && alarmLatchEnable) begin
         s_d.alarm1Latched = 1'b1;
      end else if (alarmLatchClear || !alarmLatchEnable) begin
         s_d.alarm1Latched = 1'b0;
      end
      s_d.firstAlarm = combined | (alarmLatchEnable & s_q.alarm1Latched);
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         s_q <= '{rateState: RATE_PRIME, tickCnt: RATE_TICK_RESET, default: '0};
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign firstAlarmOutput = s_q.firstAlarm;
   assign pvRateAlarm = s_q.rateAlarm;
   assign rspUpperAlarm = s_q.rspUpper;
   assign rspLowerAlarm = s_q.rspLower;
   assign heaterOpenAlarmA = openArr[0];
   assign heaterOpenAlarmB = openArr[1];
   assign heaterLeakShortAlarmA = leakArr[0];
   assign heaterLeakShortAlarmB = leakArr[1];
   assign heaterOvercurrentAlarmA = overArr[0];
   assign heaterOvercurrentAlarmB = overArr[1];
   assign heaterCurrentMonitorA = onMonArr[0];
   assign heaterCurrentMonitorB = onMonArr[1];
   assign leakageCurrentMonitorA = offMonArr[0];
   assign leakageCurrentMonitorB = offMonArr[1];

endmodule : heater_current_and_rate_alarms

`default_nettype wire

// ===== src/heater_current_channel.sv
// One current-sensing channel: interval timing, alarm evaluation, monitors
`default_nettype none

module heater_current_channel
   import heater_alarm_pkg::*;
#(
   parameter int MIN_CYCLES = MIN_INTERVAL_CYCLES
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic sampleTick,
   input wire logic heatingOn,
   input wire logic [15:0] currentSense,
   input wire logic [15:0] openThreshold,
   input wire logic [15:0] leakThreshold,
   input wire logic [15:0] overThreshold,
   output logic heaterOpenAlarm,
   output logic heaterLeakShortAlarm,
   output logic heaterOvercurrentAlarm,
   output logic [15:0] heaterCurrentMonitor,
   output logic [15:0] leakageCurrentMonitor
);

   typedef struct packed {
      logic phaseOn;
      logic [INTERVAL_CNT_W-1:0] intervalCnt;
      logic sampleSeen;
      logic [15:0] lastCurrent;
      logic openAlarm;
      logic leakAlarm;
      logic overAlarm;
      logic [15:0] onMonitor;
      logic [15:0] offMonitor;
   } chan_state_s;

   chan_state_s s_q;
   chan_state_s s_d;

   localparam logic [INTERVAL_CNT_W-1:0] MIN_CNT = INTERVAL_CNT_W'(MIN_CYCLES);

   function automatic logic [15:0] monitorValue(input logic [15:0] cur);
      monitorValue = (cur > CUR_OVERFLOW_LIMIT) ? CUR_OVERFLOW_CODE : cur;
   endfunction : monitorValue

   always_comb begin
      s_d = s_q;
      if (heatingOn != s_q.phaseOn) begin
         // Interval just ended; judge it only if long enough and sampled
         if (s_q.intervalCnt > MIN_CNT && s_q.sampleSeen) begin
            if (s_q.phaseOn) begin
               if (s_q.lastCurrent < openThreshold) begin
                  s_d.openAlarm = 1'b1;
               end else if (s_q.lastCurrent > openThreshold) begin
                  s_d.openAlarm = 1'b0;
               end
               if (s_q.lastCurrent > overThreshold) begin
                  s_d.overAlarm = 1'b1;
               end else if (s_q.lastCurrent < overThreshold) begin
                  s_d.overAlarm = 1'b0;
               end
            end else begin
               if (s_q.lastCurrent > leakThreshold) begin
                  s_d.leakAlarm = 1'b1;
               end else if (s_q.lastCurrent < leakThreshold) begin
                  s_d.leakAlarm = 1'b0;
               end
            end
         end
         s_d.phaseOn = heatingOn;
         s_d.intervalCnt = '0;
         s_d.sampleSeen = 1'b0;
      end else begin
         if (s_q.intervalCnt != '1) begin
            s_d.intervalCnt = s_q.intervalCnt + INTERVAL_CNT_W'(1);
         end
         if (sampleTick) begin
            s_d.lastCurrent = currentSense;
            s_d.sampleSeen = 1'b1;
            if (s_q.phaseOn) begin
               s_d.onMonitor = monitorValue(currentSense);
            end else begin
               s_d.offMonitor = monitorValue(currentSense);
            end
         end
      end
      // Disabled thresholds pin the alarms regardless of measurement
      if (openThreshold == CUR_FORCE_LOW) begin
         s_d.openAlarm = 1'b0;
      end else if (openThreshold >= CUR_FORCE_HIGH) begin
         s_d.openAlarm = 1'b1;
      end
      if (leakThreshold == CUR_FORCE_LOW) begin
         s_d.leakAlarm = 1'b1;
      end else if (leakThreshold >= CUR_FORCE_HIGH) begin
         s_d.leakAlarm = 1'b0;
      end
      if (overThreshold == CUR_FORCE_LOW) begin
         s_d.overAlarm = 1'b1;
      end else if (overThreshold >= CUR_FORCE_HIGH) begin
         s_d.overAlarm = 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign heaterOpenAlarm = s_q.openAlarm;
   assign heaterLeakShortAlarm = s_q.leakAlarm;
   assign heaterOvercurrentAlarm = s_q.overAlarm;
   assign heaterCurrentMonitor = s_q.onMonitor;
   assign leakageCurrentMonitor = s_q.offMonitor;

endmodule : heater_current_channel

`default_nettype wire
